/* hdl/oss_cfg.svh */
// Offsets, field positions, reset values and timing figures of the block
`ifndef OSS_CFG_SVH
`define OSS_CFG_SVH

// Register byte addresses
`define OSS_ADDR_STATUS_CONTROL 4'h0
`define OSS_ADDR_TRIM           4'h4
`define OSS_ADDR_PIN_CONFIG     4'h8

// oscillator_status_control fields
`define OSS_SRC_MSB    7
`define OSS_SRC_LSB    6
`define OSS_FREQ_MSB   5
`define OSS_FREQ_LSB   4
`define OSS_REQ_BIT    3
`define OSS_ENG_BIT    2
`define OSS_RANGE_MSB  1
`define OSS_RANGE_LSB  0

// pin_config fields
`define OSS_OUT_EN_BIT 0
`define OSS_RIS_BIT    1

// Reset values
`define OSS_RST_SRC    2'h0
`define OSS_RST_FREQ   2'h2
`define OSS_RST_RANGE  2'h0
`define OSS_RST_TRIM   8'h80
`define OSS_TRIM_MID   9'h080

// Frequencies in kHz and the system clock rate
`define OSS_CLK_KHZ    100000
`define OSS_F4M0_KHZ   4000
`define OSS_F8M0_KHZ   8000
`define OSS_F12M8_KHZ  12800

// Trim step of about 0.2 percent, as a shift of 1/512
`define OSS_TRIM_SHIFT 9

// External rising edges required before the switch
`define OSS_EXT_EDGES  2'h2

// AXI responses
`define OSS_RESP_OKAY  2'h0
`define OSS_RESP_SLVERR 2'h2

`endif

/* hdl/oss_pkg.sv */
// Types of the oscillator source selection block
package oss_pkg;

    typedef enum logic [2:0] {
        OSS_S_INT    = 3'b000,
        OSS_S_WAIT   = 3'b001,
        OSS_S_TO_EXT = 3'b010,
        OSS_S_EXT    = 3'b011,
        OSS_S_TO_INT = 3'b100
    } oss_state_t;

    typedef enum logic [1:0] {
        OSS_SRC_INTERNAL = 2'b00,
        OSS_SRC_EXT_CLK  = 2'b01,
        OSS_SRC_EXT_RC   = 2'b10,
        OSS_SRC_CRYSTAL  = 2'b11
    } oss_source_t;

endpackage

/* hdl/oss_top.sv */
// Oscillator source selection with AXI4-Lite register access
//
// Behaviour
// - No interrupt output of any kind.
// - Wait mode leaves oscillator and both bus clocks running.
// - In stop mode with stop_osc_disable the oscillator runs only when run_in_stop is set.
// - No status flags; break state touches no bit here.
// - clock_in_pin serves crystal, RC or external clock input.
// - Internal source releases clock_in_pin to the port logic.
// - Crystal option drives inverted clock_in_pin on clock_out_pin.
// - External clock, or internal or RC without clock_out_pin_enable, leave clock_out_pin to the port.
// - Internal or RC with clock_out_pin_enable outputs quad bus clock.
// - clock_source_select: internal, external, RC, crystal; reset internal.
// - internal_freq_select: 4.0, 8.0, 12.8 MHz; 12.8 at reset.
// - crystal_range_select enables the matching crystal amplifier.
// - external_clock_request starts the switch; cleared by reset.
// - external_clock_request ignored under monitor bypass.
// - external_clock_engaged reads 1 while external source drives.
// - Each trim step changes the period by about 0.2 percent.
// - Trim is relative to the selected internal frequency.
// - Two external rising edges, clean switch, engaged, then stop.
// - Quad clock equals input clock; double clock is half of it.
// - Clearing source and request returns to the internal source.
// - External clock option forces clock_out_pin_enable to zero.
`timescale 1ns/1ps
`include "oss_cfg.svh"

module oss_top #(
    parameter int ACC_WIDTH = 24
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // AXI4-Lite write address
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // System integration side
    input  wire logic        stop_mode,
    input  wire logic        stop_osc_disable,
    input  wire logic        monitor_bypass,
    output logic             quad_bus_clock,
    output logic             double_bus_clock,
    // Oscillator pins
    input  wire logic        clock_in_pin,
    output logic             clock_in_claim,
    output logic             clock_out_pin_o,
    output logic             clock_out_pin_oe,
    output logic             clock_out_claim,
    // Analogue controls
    output logic [2:0]       crystal_amp_enable,
    output logic             internal_osc_running
);
    import oss_pkg::*;

    if (ACC_WIDTH < 16 || ACC_WIDTH > 30) begin : g_width_check
        $error("oss_top: ACC_WIDTH out of range");
    end

    // Phase increments per system clock for each internal frequency
    localparam logic [63:0] ACC_ONE = 64'h1 << ACC_WIDTH;
    localparam logic [ACC_WIDTH-1:0] INC_4M0 = ACC_WIDTH'(
        ACC_ONE * 64'(`OSS_F4M0_KHZ) / 64'(`OSS_CLK_KHZ));
    localparam logic [ACC_WIDTH-1:0] INC_8M0 = ACC_WIDTH'(
        ACC_ONE * 64'(`OSS_F8M0_KHZ) / 64'(`OSS_CLK_KHZ));
    localparam logic [ACC_WIDTH-1:0] INC_12M8 = ACC_WIDTH'(
        ACC_ONE * 64'(`OSS_F12M8_KHZ) / 64'(`OSS_CLK_KHZ));

    function automatic logic map_hit(input logic [3:0] a);
        map_hit = (a == `OSS_ADDR_STATUS_CONTROL) ||
                  (a == `OSS_ADDR_TRIM) ||
                  (a == `OSS_ADDR_PIN_CONFIG);
    endfunction

    // Software visible state
    oss_source_t source_reg;
    logic [1:0]  freq_reg;
    logic [1:0]  range_reg;
    logic        request_reg;
    logic        engaged_reg;
    logic [7:0]  trim_reg;
    logic        out_en_reg;
    logic        run_in_stop_reg;

    // Bus slave state
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [3:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        wr_fire;
    logic        wr_hit;

    // Clock path state
    oss_state_t          state_reg;
    logic [ACC_WIDTH-1:0] acc_reg;
    logic                 pin_prev_reg;
    logic [1:0]           edges_reg;
    logic                 sel_ext_reg;
    logic                 quad_prev_reg;
    logic                 int_clk;
    logic                 int_run;
    logic                 osc_on;
    logic                 ext_rise;
    logic                 want_ext;
    logic                 drop_ext;
    logic [ACC_WIDTH-1:0] base_inc;
    logic [ACC_WIDTH-1:0] trim_inc;

    // Only one write in flight; the response must drain first
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = aw_held_reg && w_held_reg;
    assign wr_hit  = wr_fire && map_hit(awaddr_reg) && wstrb_reg[0];

    always_ff @(posedge clk) begin
        if (reset) begin
            aw_held_reg <= 1'b0;
            awaddr_reg  <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            w_held_reg <= 1'b0;
            wdata_reg  <= 32'h0;
            wstrb_reg  <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `OSS_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= map_hit(awaddr_reg) ? `OSS_RESP_OKAY
                                                : `OSS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `OSS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= map_hit(s_axi_araddr) ? `OSS_RESP_OKAY
                                                  : `OSS_RESP_SLVERR;
            unique case (s_axi_araddr)
                `OSS_ADDR_STATUS_CONTROL:
                    s_axi_rdata <= {24'h0, source_reg, freq_reg,
                                    request_reg, engaged_reg,
                                    range_reg};
                `OSS_ADDR_TRIM:
                    s_axi_rdata <= {24'h0, trim_reg};
                `OSS_ADDR_PIN_CONFIG:
                    s_axi_rdata <= {30'h0, run_in_stop_reg, out_en_reg};
                default:
                    s_axi_rdata <= 32'h0;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Status and control fields; engaged bit is not writable
    always_ff @(posedge clk) begin
        if (reset) begin
            source_reg  <= OSS_SRC_INTERNAL;
            freq_reg    <= `OSS_RST_FREQ;
            range_reg   <= `OSS_RST_RANGE;
            request_reg <= 1'b0;
        end else if (wr_hit && awaddr_reg == `OSS_ADDR_STATUS_CONTROL) begin
            source_reg  <= oss_source_t'(
                           wdata_reg[`OSS_SRC_MSB:`OSS_SRC_LSB]);
            freq_reg    <= wdata_reg[`OSS_FREQ_MSB:`OSS_FREQ_LSB];
            range_reg   <= wdata_reg[`OSS_RANGE_MSB:`OSS_RANGE_LSB];
            request_reg <= wdata_reg[`OSS_REQ_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            trim_reg <= `OSS_RST_TRIM;
        end else if (wr_hit && awaddr_reg == `OSS_ADDR_TRIM) begin
            trim_reg <= wdata_reg[7:0];
        end
    end

    // Pin enable is held clear while the external clock option is chosen
    always_ff @(posedge clk) begin
        if (reset) begin
            out_en_reg      <= 1'b0;
            run_in_stop_reg <= 1'b0;
        end else begin
            if (wr_hit && awaddr_reg == `OSS_ADDR_PIN_CONFIG) begin
                run_in_stop_reg <= wdata_reg[`OSS_RIS_BIT];
            end
            if (source_reg == OSS_SRC_EXT_CLK) begin
                out_en_reg <= 1'b0;
            end else if (wr_hit && awaddr_reg == `OSS_ADDR_PIN_CONFIG) begin
                out_en_reg <= wdata_reg[`OSS_OUT_EN_BIT];
            end
        end
    end

    // Stop mode with stop_osc_disable shuts the oscillator unless run_in_stop overrides;
    // wait mode has no input here, so the clocks keep running
    assign osc_on = !(stop_mode && stop_osc_disable &&
                      !run_in_stop_reg);

    // Internal oscillator as a phase accumulator; reserved code falls
    // back to the reset frequency and is not a supported setting
    always_comb begin
        unique case (freq_reg)
            2'h0:    base_inc = INC_4M0;
            2'h1:    base_inc = INC_8M0;
            2'h2:    base_inc = INC_12M8;
            default: base_inc = INC_12M8;
        endcase
    end

    // Larger trim lowers the increment, lengthening the period, scaled
    // from the selected base so the step stays relative to it
    always_comb begin
        logic signed [8:0]           offs;
        logic signed [ACC_WIDTH+9:0] prod;
        offs = $signed({1'b0, trim_reg}) - $signed(`OSS_TRIM_MID);
        prod = $signed({1'b0, base_inc}) * offs;
        trim_inc = base_inc - ACC_WIDTH'(prod >>> `OSS_TRIM_SHIFT);
    end

    assign int_run = osc_on && (state_reg != OSS_S_EXT);
    assign int_clk = acc_reg[ACC_WIDTH-1];

    always_ff @(posedge clk) begin
        if (reset) begin
            acc_reg <= '0;
        end else if (int_run) begin
            acc_reg <= acc_reg + trim_inc;
        end
    end

    // Switching requests
    assign ext_rise = clock_in_pin && !pin_prev_reg;
    assign want_ext = request_reg && source_reg != OSS_SRC_INTERNAL &&
                      !monitor_bypass;
    assign drop_ext = !request_reg ||
                      source_reg == OSS_SRC_INTERNAL;

    always_ff @(posedge clk) begin
        if (reset) begin
            pin_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg <= clock_in_pin;
        end
    end

    // Mux changes only while both clocks are low, so no short phase
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg   <= OSS_S_INT;
            edges_reg   <= 2'h0;
            sel_ext_reg <= 1'b0;
            engaged_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                OSS_S_INT: begin
                    edges_reg <= 2'h0;
                    if (want_ext) begin
                        state_reg <= OSS_S_WAIT;
                    end
                end
                OSS_S_WAIT: begin
                    if (drop_ext) begin
                        state_reg <= OSS_S_INT;
                    end else if (ext_rise) begin
                        edges_reg <= edges_reg + 2'h1;
                        if (edges_reg + 2'h1 == `OSS_EXT_EDGES) begin
                            state_reg <= OSS_S_TO_EXT;
                        end
                    end
                end
                OSS_S_TO_EXT: begin
                    if (drop_ext) begin
                        state_reg <= OSS_S_INT;
                    end else if (!int_clk && !clock_in_pin) begin
                        sel_ext_reg <= 1'b1;
                        engaged_reg <= 1'b1;
                        state_reg   <= OSS_S_EXT;
                    end
                end
                OSS_S_EXT: begin
                    if (drop_ext) begin
                        state_reg <= OSS_S_TO_INT;
                    end
                end
                OSS_S_TO_INT: begin
                    if (!int_clk && !clock_in_pin) begin
                        sel_ext_reg <= 1'b0;
                        engaged_reg <= 1'b0;
                        state_reg   <= OSS_S_INT;
                    end
                end
                default: begin
                    state_reg <= OSS_S_INT;
                end
            endcase
        end
    end

    // Bus clocks; no interrupt is generated anywhere in this block
    // and it keeps no flags for break handling to protect
    always_ff @(posedge clk) begin
        if (reset) begin
            quad_bus_clock <= 1'b0;
            quad_prev_reg  <= 1'b0;
        end else begin
            quad_bus_clock <= osc_on &&
                (sel_ext_reg ? clock_in_pin : int_clk);
            quad_prev_reg  <= quad_bus_clock;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            double_bus_clock <= 1'b0;
        end else if (quad_bus_clock && !quad_prev_reg) begin
            double_bus_clock <= !double_bus_clock;
        end
    end

    // Pin ownership
    assign clock_in_claim = source_reg != OSS_SRC_INTERNAL;
    assign clock_out_claim = source_reg == OSS_SRC_CRYSTAL ||
        (out_en_reg && (source_reg == OSS_SRC_INTERNAL ||
                        source_reg == OSS_SRC_EXT_RC));
    assign clock_out_pin_oe = clock_out_claim;

    always_ff @(posedge clk) begin
        if (reset) begin
            clock_out_pin_o <= 1'b0;
        end else if (source_reg == OSS_SRC_CRYSTAL) begin
            clock_out_pin_o <= !clock_in_pin;
        end else begin
            clock_out_pin_o <= quad_bus_clock;
        end
    end

    // Crystal amplifier per range; reserved code enables none
    always_ff @(posedge clk) begin
        if (reset) begin
            crystal_amp_enable <= 3'h0;
        end else if (source_reg == OSS_SRC_CRYSTAL && osc_on) begin
            unique case (range_reg)
                2'h0:    crystal_amp_enable <= 3'h1;
                2'h1:    crystal_amp_enable <= 3'h2;
                2'h2:    crystal_amp_enable <= 3'h4;
                default: crystal_amp_enable <= 3'h0;
            endcase
        end else begin
            crystal_amp_enable <= 3'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            internal_osc_running <= 1'b0;
        end else begin
            internal_osc_running <= int_run;
        end
    end

endmodule // oss_top

/* tb/oss_properties.sv */
// Port checks for the oscillator source selection block
`timescale 1ns/1ps

module oss_checker (
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset,
    // Bus answers
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    // System side
    input wire logic       stop_mode,
    input wire logic       quad_bus_clock,
    input wire logic       double_bus_clock,
    // Pins and analogue controls
    input wire logic       clock_in_pin,
    input wire logic       clock_in_claim,
    input wire logic       clock_out_pin_o,
    input wire logic       clock_out_pin_oe,
    input wire logic       clock_out_claim,
    input wire logic [2:0] crystal_amp_enable,
    input wire logic       internal_osc_running
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    amp_onehot_a: assert property ($onehot0(crystal_amp_enable))
        else $error("crystal amplifier enable not one-hot");
    amp_pins_a: assert property (|crystal_amp_enable |->
        $past(clock_in_claim && clock_out_claim))
        else $error("crystal amplifier on without both pins");
    crystal_invert_a: assert property (
        |crystal_amp_enable && $past(|crystal_amp_enable) |->
        clock_out_pin_o == !$past(clock_in_pin))
        else $error("clock_out_pin not inverted clock_in_pin");
    out_enable_a: assert property (
        clock_out_pin_oe == clock_out_claim)
        else $error("output enable differs from pin claim");
    bus_clock_out_a: assert property (
        clock_out_claim && !clock_in_claim ##1
        clock_out_claim && !clock_in_claim |->
        clock_out_pin_o == $past(quad_bus_clock))
        else $error("clock_out_pin not the quad bus clock");
    double_half_a: assert property ($changed(double_bus_clock) |->
        quad_bus_clock || $past(quad_bus_clock))
        else $error("double clock moved without quad rising");
    osc_stop_cause_a: assert property (
        $fell(internal_osc_running) |->
        clock_in_claim || stop_mode || $past(stop_mode) || $past(stop_mode, 2))
        else $error("internal oscillator stopped without cause");
    osc_alive_a: assert property (
        !clock_in_claim && !stop_mode && internal_osc_running |->
        ##[1:40] ($changed(quad_bus_clock) || stop_mode))
        else $error("internal bus clock stalled");
    ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted with data pending");
endmodule // oss_checker

bind oss_top oss_checker oss_checker_i (.clk(clk), .reset(reset),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .stop_mode(stop_mode), .quad_bus_clock(quad_bus_clock),
    .double_bus_clock(double_bus_clock), .clock_in_pin(clock_in_pin),
    .clock_in_claim(clock_in_claim), .clock_out_pin_o(clock_out_pin_o),
    .clock_out_pin_oe(clock_out_pin_oe), .clock_out_claim(clock_out_claim),
    .crystal_amp_enable(crystal_amp_enable),
    .internal_osc_running(internal_osc_running));

/* tb/oss_ext_clock.sv */
// External clock source model driving the clock input pin
`timescale 1ns/1ps

module oss_ext_clock #(
    parameter realtime HALF = 37.0
) (
    // Control
    input  wire logic run,
    // Pin
    output logic      pin_clock
);
    // Held low while stopped, so no stray edge can start a switch
    initial begin
        pin_clock = 1'b0;
        forever begin
            #(HALF);
            pin_clock = run ? ~pin_clock : 1'b0;
        end
    end
endmodule // oss_ext_clock

/* tb/oss_top_bench.sv */
// Self-checking bench for the oscillator source selection block
`timescale 1ns/1ps
`include "oss_cfg.svh"

module oss_top_bench;
    import oss_pkg::*;
    localparam logic [3:0] SC   = `OSS_ADDR_STATUS_CONTROL;
    localparam logic [3:0] TRIM = `OSS_ADDR_TRIM;
    localparam logic [3:0] PIN  = `OSS_ADDR_PIN_CONFIG;
    localparam logic [1:0] OK   = `OSS_RESP_OKAY;
    localparam logic [1:0] ERR  = `OSS_RESP_SLVERR;
    localparam real        F12  = 800000.0 / `OSS_F12M8_KHZ;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, ext_run = 1'b0;
    logic        stop_mode = 1'b0, stop_osc_disable = 1'b0;
    logic        monitor_bypass = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        quad, dbl, pin_in, in_claim, out_o, out_oe, out_claim;
    logic        osc_run;
    logic [2:0]  amp;
    logic [7:0]  d;
    int          mismatches = 0;
    int          num_checks = 0;
    real         khz [3] = '{`OSS_F4M0_KHZ, `OSS_F8M0_KHZ, `OSS_F12M8_KHZ};

    always #5 clk = ~clk;

    oss_top oss_top_i (.clk(clk), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .stop_mode(stop_mode),
        .stop_osc_disable(stop_osc_disable),
        .monitor_bypass(monitor_bypass), .quad_bus_clock(quad),
        .double_bus_clock(dbl), .clock_in_pin(pin_in),
        .clock_in_claim(in_claim), .clock_out_pin_o(out_o),
        .clock_out_pin_oe(out_oe), .clock_out_claim(out_claim),
        .crystal_amp_enable(amp), .internal_osc_running(osc_run));
    oss_ext_clock oss_ext_clock_i (.run(ext_run), .pin_clock(pin_in));

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic timeout();
        chk_val(8'h00, 8'h01);
        final_report();
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        if (n >= 50) timeout();
        chk_val({6'h0, bresp}, {6'h0, er});
    endtask

    task automatic rd(input logic [3:0] a, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        if (n >= 50) timeout();
        chk_val({6'h0, rresp}, {6'h0, er});
        d = rdata[7:0];
    endtask

    // Skips two edges: the first period may straddle a setting change
    task automatic chk_period(input bit use_dbl, input int edges,
                              input real exp);
        int seen;
        int cyc;
        int n;
        logic prev, cur;
        seen = -2;
        cyc = 0;
        n = 0;
        prev = use_dbl ? dbl : quad;
        while (seen < edges && n < 4000) begin
            @(posedge clk);
            n++;
            cur = use_dbl ? dbl : quad;
            if (seen >= 0) cyc++;
            if (cur && !prev) seen++;
            prev = cur;
        end
        if (n >= 4000) timeout();
        num_checks++;
        if (cyc < exp - 2.0 || cyc > exp + 2.0) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, cyc,
                     int'(exp));
        end
    endtask

    task automatic wait_engaged(input logic v);
        int n;
        n = 0;
        do begin
            rd(SC, OK);
            n++;
        end while (d[2] !== v && n < 20);
        if (d[2] !== v) timeout();
        chk_val({7'h0, d[2]}, {7'h0, v});
    endtask

    task automatic t_regs();
        rd(SC, OK);
        chk_val(d, 8'h20);
        wr(SC, 8'h24, OK);
        rd(SC, OK);
        chk_val(d, 8'h20);
        rd(TRIM, OK);
        chk_val(d, `OSS_RST_TRIM);
        rd(4'hC, ERR);
        wr(4'hC, 8'hFF, ERR);
    endtask

    task automatic t_freq();
        for (int i = 0; i < 3; i++) begin
            wr(SC, {2'b00, 2'(i), 4'h0}, OK);
            chk_period(0, 8, 800000.0 / khz[i]);
            chk_period(1, 4, 800000.0 / khz[i]);
        end
        for (int t = 0; t < 2; t++) begin
            wr(TRIM, t ? 8'h70 : 8'h90, OK);
            for (int i = 0; i < 2; i++) begin
                wr(SC, {2'b00, 2'(i), 4'h0}, OK);
                chk_period(0, 8, 800000.0 / khz[i] *
                    (1.0 + (t ? -16.0 : 16.0) / 512.0));
            end
        end
        wr(TRIM, 8'h80, OK);
        wr(SC, 8'h20, OK);
    endtask

    task automatic t_pins();
        logic [2:0] amp_exp [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
        wr(PIN, 8'h01, OK);
        chk_val({6'h0, in_claim, out_oe}, 8'h01);
        wr(SC, 8'hA0, OK);
        chk_val({6'h0, in_claim, out_oe}, 8'h03);
        wr(SC, 8'h60, OK);
        chk_val({6'h0, in_claim, out_oe}, 8'h02);
        wr(PIN, 8'h01, OK);
        rd(PIN, OK);
        chk_val(d, 8'h00);
        for (int r = 0; r < 4; r++) begin
            wr(SC, {4'hE, 2'b00, 2'(r)}, OK);
            repeat (2) @(posedge clk);
            chk_val({4'h0, out_oe, amp},
                    {5'h1, amp_exp[r]});
        end
        wr(SC, 8'h20, OK);
        wr(PIN, 8'h00, OK);
        chk_val({6'h0, in_claim, out_oe}, 8'h00);
    endtask

    task automatic t_switch();
        wr(SC, 8'h60, OK);
        wr(SC, 8'h68, OK);
        repeat (30) @(posedge clk);
        rd(SC, OK);
        chk_val(d, 8'h68);
        ext_run <= 1'b1;
        wait_engaged(1'b1);
        repeat (2) @(posedge clk);
        chk_val({7'h0, osc_run}, 8'h00);
        chk_period(0, 8, 8.0 * 74.0 / 10.0);
        wr(SC, 8'h20, OK);
        wait_engaged(1'b0);
        repeat (2) @(posedge clk);
        chk_val({7'h0, osc_run}, 8'h01);
        chk_period(0, 8, F12);
        ext_run <= 1'b0;
    endtask

    task automatic t_monitor();
        monitor_bypass <= 1'b1;
        ext_run <= 1'b1;
        wr(SC, 8'h68, OK);
        repeat (40) @(posedge clk);
        rd(SC, OK);
        chk_val({7'h0, d[2]}, 8'h00);
        wr(SC, 8'h20, OK);
        monitor_bypass <= 1'b0;
        ext_run <= 1'b0;
    endtask

    task automatic t_stop();
        logic hi;
        hi = 1'b0;
        stop_osc_disable <= 1'b1;
        stop_mode <= 1'b1;
        repeat (3) @(posedge clk);
        for (int k = 0; k < 40; k++) begin
            @(posedge clk);
            hi = hi | quad;
        end
        chk_val({6'h0, hi, osc_run}, 8'h00);
        wr(PIN, 8'h02, OK);
        chk_period(0, 8, F12);
        stop_mode <= 1'b0;
        wr(PIN, 8'h00, OK);
        stop_osc_disable <= 1'b0;
        chk_period(0, 8, F12);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_freq();
        t_pins();
        t_switch();
        t_monitor();
        t_stop();
        final_report();
    end
endmodule // oss_top_bench
